// *** verilog/tmc_cfg.svh ***
/*
 Timer C configuration constants: register indices, field positions,
 reset values and prescaler counts.
 Assumes inclusion by bare name from the design files only.
*/
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// Register indices; byte address is four times the index
`define TMC_IDX_CLKDIV 10'h08e
`define TMC_IDX_CTRL 10'h0c8
`define TMC_IDX_RELOAD_LO 10'h0ca
`define TMC_IDX_RELOAD_HI 10'h0cb
`define TMC_IDX_COUNT_LO 10'h0cc
`define TMC_IDX_COUNT_HI 10'h0cd

// Clock-divide register fields
`define TMC_CKD_TIMER_C 5
`define TMC_CKD_TIMER_B 4
`define TMC_CKD_TIMER_A 3
`define TMC_CKD_WMASK 8'h38
`define TMC_CKD_RESET 8'h00

// Control register fields
`define TMC_CTL_OVERFLOW 7
`define TMC_CTL_RX_BAUD 5
`define TMC_CTL_TX_BAUD 4
`define TMC_CTL_RUN 2
`define TMC_CTL_SOURCE 1
`define TMC_CTL_CAPRL 0
`define TMC_CTL_WMASK 8'h37
`define TMC_CTL_RESET 8'h00

// Prescaler: system clock divided by twelve
`define TMC_PRESC_DIV 4'd12
`define TMC_PRESC_LAST 4'd11

// Count limits
`define TMC_COUNT_MAX 16'hffff
`define TMC_COUNT_RESET 16'h0000

// Bus answers
`define TMC_RESP_OKAY 2'b00
`define TMC_RESP_SLVERR 2'b10

`endif

// *** verilog/tmc_pkg.sv ***
/*
 Timer C package: the operating mode type.
 Assumes compilation before every design module that imports it.
*/
package tmc_pkg;

   // Operating modes decoded from the control bits
   typedef enum logic [2:0] {
      TMC_MODE_OFF,
      TMC_MODE_CAPTURE,
      TMC_MODE_RELOAD,
      TMC_MODE_BAUD_TX,
      TMC_MODE_BAUD_RX,
      TMC_MODE_BAUD_TXRX
   } tmc_mode_e;

   // Bus response code
   typedef logic [1:0] tmc_resp_t;

endpackage

// *** verilog/tmc_pin_sync.sv ***
/*
 Timer C pin synchroniser: two flip-flops per pin, then a falling-edge
 detector on the settled level.
 Assumes asynchronous pins and one system clock.
*/
module tmc_pin_sync (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Raw pins
   input wire logic [1:0] i_pin,
   // One-cycle falling-edge pulses
   output logic [1:0] o_fall
);

   // Per-pin synchroniser and edge detector
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         logic meta_r;   // First stage, read only by the second
         logic sync_r;   // Settled level
         logic prev_r;   // Level one cycle earlier
         logic fall_r;   // Registered edge pulse

         // Idle level of both pins is high, so reset to one
         always_ff @(posedge i_mclk or negedge i_rstn) begin
            if (!i_rstn) begin
               meta_r <= 1'b1;
               sync_r <= 1'b1;
               prev_r <= 1'b1;
               fall_r <= 1'b0;
            end else begin
               meta_r <= i_pin[g];
               sync_r <= meta_r;
               prev_r <= sync_r;
               fall_r <= prev_r & ~sync_r;
            end
         end

         assign o_fall[g] = fall_r;
      end
   endgenerate

endmodule

// *** verilog/tmc_timer.sv ***
/*
 Timer C: 16-bit counter/timer with capture, auto-reload and baud
 generation, plus the shared clock-divide register, on AXI4-Lite.
 Assumes one 20 MHz system clock, an asynchronous active-low reset and
 asynchronous count and capture pins.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "tmc_cfg.svh"

module tmc_timer (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // AXI4-Lite write address
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [11:0] i_awaddr,
   // AXI4-Lite write data
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   // AXI4-Lite write response
   output logic o_bvalid,
   input wire logic i_bready,
   output tmc_pkg::tmc_resp_t o_bresp,
   // AXI4-Lite read address
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [11:0] i_araddr,
   // AXI4-Lite read data
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output tmc_pkg::tmc_resp_t o_rresp,
   // Pins
   input wire logic i_external_count_input,
   input wire logic i_capture_input,
   // Timer events
   output logic o_overflow,
   output logic o_adc_start,
   output logic o_tx_baud_tick,
   output logic o_rx_baud_tick
);
   import tmc_pkg::*;

   // Registers seen by software, plus the hidden prescaler
   logic [7:0] clkdiv_r;       // Clock-divide register
   logic [7:0] ctrl_r;         // Control register
   logic [15:0] count_r;       // Running count
   logic [15:0] reload_r;      // Reload value or captured count
   logic [3:0] presc_r;        // Divide-by-twelve prescaler

   // Bus slave state
   logic awready_r;            // High while no address held
   logic wready_r;             // High while no data held
   logic bvalid_r;
   tmc_resp_t bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   tmc_resp_t rresp_r;
   logic [9:0] wr_idx_r;       // Held write index
   logic [7:0] wr_data_r;      // Held low byte of write data
   logic wr_lane_r;            // Byte lane zero enabled

   // Event outputs
   logic ovf_r;
   logic adc_r;
   logic tx_tick_r;
   logic rx_tick_r;

   // Synchronised pin edges
   logic [1:0] pin_fall;
   logic ext_fall;
   logic cap_fall;

   // Edges lag their pins by a few cycles; harmless at pin rates
   tmc_pin_sync u_sync (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_pin({i_capture_input, i_external_count_input}),
      .o_fall(pin_fall)
   );

   assign ext_fall = pin_fall[0];
   assign cap_fall = pin_fall[1];

   // Control bit views
   wire run_bit = ctrl_r[`TMC_CTL_RUN];
   wire count_source_select = ctrl_r[`TMC_CTL_SOURCE];
   wire capture_reload_select = ctrl_r[`TMC_CTL_CAPRL];
   wire transmit_baud_select = ctrl_r[`TMC_CTL_TX_BAUD];
   wire receive_baud_select = ctrl_r[`TMC_CTL_RX_BAUD];
   wire timer_c_clock_divide_bit = clkdiv_r[`TMC_CKD_TIMER_C];

   // Mode decode; run clear forces off whatever the other bits say
   // Baud selects outrank the capture bit, which they ignore
   wire any_baud = transmit_baud_select | receive_baud_select;
   tmc_mode_e mode;
   assign mode = !run_bit ? TMC_MODE_OFF :
      (transmit_baud_select && receive_baud_select) ? TMC_MODE_BAUD_TXRX :
      transmit_baud_select ? TMC_MODE_BAUD_TX :
      receive_baud_select ? TMC_MODE_BAUD_RX :
      capture_reload_select ? TMC_MODE_CAPTURE :
      TMC_MODE_RELOAD;

   // Tick source selection
   wire presc_wrap = (presc_r == `TMC_PRESC_LAST);
   wire sys_tick = timer_c_clock_divide_bit ? 1'b1 : presc_wrap;
   wire tick = count_source_select ? ext_fall : sys_tick;
   wire running = (mode != TMC_MODE_OFF);
   wire step = running & tick;
   wire at_max = (count_r == `TMC_COUNT_MAX);
   wire wrap = step & at_max;

   // Capture mode wraps to zero; reload and baud modes reload
   wire reload_on_wrap = (mode != TMC_MODE_CAPTURE);
   wire [15:0] wrap_value = reload_on_wrap ? reload_r : `TMC_COUNT_RESET;
   wire [15:0] count_inc = count_r + 16'h0001;

   // Bus write decode, performed once both halves are held
   wire wr_fire = !awready_r && !wready_r && !bvalid_r;
   wire wr_ckd = (wr_idx_r == `TMC_IDX_CLKDIV);
   wire wr_ctl = (wr_idx_r == `TMC_IDX_CTRL);
   wire wr_rlo = (wr_idx_r == `TMC_IDX_RELOAD_LO);
   wire wr_rhi = (wr_idx_r == `TMC_IDX_RELOAD_HI);
   wire wr_clo = (wr_idx_r == `TMC_IDX_COUNT_LO);
   wire wr_chi = (wr_idx_r == `TMC_IDX_COUNT_HI);
   wire wr_hit = wr_ckd | wr_ctl | wr_rlo | wr_rhi | wr_clo | wr_chi;
   wire wr_en = wr_fire & wr_lane_r;

   // Bus read decode, straight from the address channel
   wire [9:0] rd_idx = i_araddr[11:2];
   wire rd_ckd = (rd_idx == `TMC_IDX_CLKDIV);
   wire rd_ctl = (rd_idx == `TMC_IDX_CTRL);
   wire rd_rlo = (rd_idx == `TMC_IDX_RELOAD_LO);
   wire rd_rhi = (rd_idx == `TMC_IDX_RELOAD_HI);
   wire rd_clo = (rd_idx == `TMC_IDX_COUNT_LO);
   wire rd_chi = (rd_idx == `TMC_IDX_COUNT_HI);
   wire rd_hit = rd_ckd | rd_ctl | rd_rlo | rd_rhi | rd_clo | rd_chi;
   wire [7:0] rd_byte = rd_ckd ? (clkdiv_r & `TMC_CKD_WMASK) :
      rd_ctl ? ctrl_r :
      rd_rlo ? reload_r[7:0] :
      rd_rhi ? reload_r[15:8] :
      rd_clo ? count_r[7:0] :
      rd_chi ? count_r[15:8] : 8'h00;
   wire ar_take = i_arvalid & arready_r;

   // Sticky overflow: hardware set beats a software clear
   wire ovf_clear = wr_en & wr_ctl & ~wr_data_r[`TMC_CTL_OVERFLOW];
   wire ovf_flag_nxt = wrap | (ctrl_r[`TMC_CTL_OVERFLOW] & ~ovf_clear);
   wire [7:0] ctrl_bits = (wr_en & wr_ctl) ? (wr_data_r & `TMC_CTL_WMASK) :
      (ctrl_r & `TMC_CTL_WMASK);
   wire [7:0] ctrl_nxt = {ovf_flag_nxt, ctrl_bits[6:0]};

   // Count next value; a software byte write beats counting
   // Byte writes change one half; the other half keeps its value
   wire [15:0] count_nxt = (wr_en & wr_clo) ? {count_r[15:8], wr_data_r} :
      (wr_en & wr_chi) ? {wr_data_r, count_r[7:0]} :
      wrap ? wrap_value :
      step ? count_inc : count_r;

   // Reload register: software write, or capture of the running count
   wire cap_now = (mode == TMC_MODE_CAPTURE) & cap_fall;
   wire [15:0] reload_nxt = (wr_en & wr_rlo) ? {reload_r[15:8], wr_data_r} :
      (wr_en & wr_rhi) ? {wr_data_r, reload_r[7:0]} :
      cap_now ? count_r : reload_r;

   // Prescaler only advances while the timer runs
   // Clearing it on stop makes the first tick a full twelve cycles
   wire [3:0] presc_nxt = (!running || presc_wrap) ? 4'h0 : presc_r + 4'h1;

   // Timer core registers
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         count_r <= `TMC_COUNT_RESET;
         reload_r <= `TMC_COUNT_RESET;
         presc_r <= 4'h0;
      end else begin
         count_r <= count_nxt;
         reload_r <= reload_nxt;
         presc_r <= presc_nxt;
      end
   end

   // Configuration registers; reserved divide bits stay zero
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         clkdiv_r <= `TMC_CKD_RESET;
         ctrl_r <= `TMC_CTL_RESET;
      end else begin
         if (wr_en && wr_ckd) begin
            clkdiv_r <= wr_data_r & `TMC_CKD_WMASK;
         end
         ctrl_r <= ctrl_nxt;
      end
   end

   // Event pulses, one cycle each, registered so outputs are clean
   // Trigger and ticks share the wrap, so they always line up
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ovf_r <= 1'b0;
         adc_r <= 1'b0;
         tx_tick_r <= 1'b0;
         rx_tick_r <= 1'b0;
      end else begin
         ovf_r <= wrap;
         adc_r <= wrap;
         tx_tick_r <= wrap & transmit_baud_select;
         rx_tick_r <= wrap & receive_baud_select;
      end
   end

   // Write channel: hold address and data in either order
   // Limitation: one write in flight; the next waits for the response
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         wr_idx_r <= 10'h000;
      end else begin
         if (i_awvalid && awready_r) begin
            awready_r <= 1'b0;
            wr_idx_r <= i_awaddr[11:2];
         end else if (bvalid_r && i_bready) begin
            awready_r <= 1'b1;
         end
         if (i_wvalid && wready_r) begin
            wready_r <= 1'b0;
         end else if (bvalid_r && i_bready) begin
            wready_r <= 1'b1;
         end
      end
   end

   // Held write data and lane
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_data_r <= 8'h00;
         wr_lane_r <= 1'b0;
      end else if (i_wvalid && wready_r) begin
         wr_data_r <= i_wdata[7:0];
         wr_lane_r <= i_wstrb[0];
      end
   end

   // Write response; unmapped words answer with an error
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `TMC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (bvalid_r && i_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read channel: one read at a time, answered the next cycle
   // Data latched at the take, so a running count cannot tear later
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `TMC_RESP_OKAY;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rd_byte};
         rresp_r <= rd_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (rvalid_r && i_rready) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // Outputs straight from flip-flops
   // Pulse outputs last one cycle; consumers must sample every edge
   assign o_awready = awready_r;
   assign o_wready = wready_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_arready = arready_r;
   assign o_rvalid = rvalid_r;
   assign o_rdata = rdata_r;
   assign o_rresp = rresp_r;
   assign o_overflow = ovf_r;
   assign o_adc_start = adc_r;
   assign o_tx_baud_tick = tx_tick_r;
   assign o_rx_baud_tick = rx_tick_r;

endmodule

// *** tb/tmc_checker.sv ***
/* Timer C checker: bus answers and timer event relations.
   Assumes a bind to tmc_timer, one clock, active-low reset. */
module tmc_checker (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Register bus
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire tmc_pkg::tmc_resp_t o_bresp,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   // Timer events
   input wire logic o_overflow,
   input wire logic o_adc_start,
   input wire logic o_tx_baud_tick,
   input wire logic o_rx_baud_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   import tmc_pkg::*;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // Trigger and ticks are views of the one wrap
   a_adc_on_wrap: assert property (o_adc_start == o_overflow)
      else $error("adc start differs from overflow");
   a_tx_on_wrap: assert property (o_tx_baud_tick |-> o_overflow)
      else $error("tx tick without overflow");
   a_rx_on_wrap: assert property (o_rx_baud_tick |-> o_overflow)
      else $error("rx tick without overflow");
   // Reads answer one cycle after the take, writes two, held until taken
   // Ready drops at the take; a write response follows one cycle later
   a_write_answer: assert property (
      i_awvalid && o_awready && i_wvalid && o_wready |=> !o_awready ##1 o_bvalid)
      else $error("write not answered");
   a_b_release: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
      else $error("write answer not released");
   a_b_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read not answered");
   // Registers are one byte wide
   a_byte_wide: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("read data above byte");
endmodule
bind tmc_timer tmc_checker u_tmc_checker (.i_mclk(i_mclk), .i_rstn(i_rstn),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
   .o_overflow(o_overflow), .o_adc_start(o_adc_start), .o_tx_baud_tick(o_tx_baud_tick),
   .o_rx_baud_tick(o_rx_baud_tick));

// *** tb/tmc_pin_model.sv ***
/* Timer C far side: count and capture pins, baud tick consumer.
   Assumes the bench calls falls() right after a clock edge. */
module tmc_pin_model (
   // Clock and ticks
   input wire logic i_mclk,
   input wire logic i_tx_tick,
   input wire logic i_rx_tick,
   // Pins, pulled up when idle
   output logic o_count_pin = 1'b1,
   output logic o_capture_pin = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_tx = 0; // Ticks taken by the transmitter
   int n_rx = 0; // Ticks taken by the receiver
   // Serial side takes one tick per bit time
   always @(posedge i_mclk) begin
      n_tx <= n_tx + int'(i_tx_tick);
      n_rx <= n_rx + int'(i_rx_tick);
   end
   // Three cycles per level so the synchroniser sees each fall
   task automatic falls(input logic cap, input int n);
      repeat (n) begin
         o_count_pin <= cap;
         o_capture_pin <= !cap;
         repeat (3) @(posedge i_mclk);
         o_count_pin <= 1'b1;
         o_capture_pin <= 1'b1;
         repeat (3) @(posedge i_mclk);
      end
   endtask
endmodule

// *** tb/tb_top.sv ***
/* Timer C bench: register tests over AXI4-Lite, pin and mode checks.
   Assumes tmc_timer, tmc_pin_model and the bound checker. */
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD %0t got %0h want %0h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmc_pkg::*;
   localparam logic [11:0] adr_div = 12'h238, adr_ctl = 12'h320, adr_rlo = 12'h328;
   localparam logic [11:0] adr_rhi = 12'h32c, adr_clo = 12'h330, adr_chi = 12'h334;
   logic i_mclk = 1'b0, i_rstn = 1'b0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_wstrb = 4'h0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, cnt_pin, cap_pin;
   logic o_overflow, o_adc_start, o_tx_baud_tick, o_rx_baud_tick, tx_seen, rx_seen, adc_seen;
   tmc_resp_t o_bresp, o_rresp;
   logic [31:0] o_rdata;
   logic [7:0] modes [5] = '{8'h04, 8'h05, 8'h14, 8'h24, 8'h35}; // Reload, capture, baud
   int n_errors = 0, n_compared = 0, cyc;
   tmc_timer u_tmc_timer (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .i_external_count_input(cnt_pin), .i_capture_input(cap_pin), .o_overflow(o_overflow),
      .o_adc_start(o_adc_start), .o_tx_baud_tick(o_tx_baud_tick),
      .o_rx_baud_tick(o_rx_baud_tick));
   tmc_pin_model u_tmc_pin_model (.i_mclk(i_mclk), .i_tx_tick(o_tx_baud_tick),
      .i_rx_tick(o_rx_baud_tick), .o_count_pin(cnt_pin), .o_capture_pin(cap_pin));
   // 20 MHz clock
   always #25 i_mclk = ~i_mclk;
   // Verdict; a hang counts as one mismatch
   task automatic conclude(input logic hung);
      if (hung) n_errors++;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One bus transfer; each channel held until its own ready
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
      input tmc_resp_t er);
      logic pa, pw, pr, ta, tw, tr, dn;
      tmc_resp_t r;
      logic [31:0] rdv;
      pa = w;
      pw = w;
      pr = !w;
      dn = 1'b0;
      @(posedge i_mclk);
      i_awvalid <= w;
      i_wvalid <= w;
      i_awaddr <= a;
      i_wdata <= {24'h0, d};
      i_wstrb <= 4'h1;
      i_bready <= w;
      i_arvalid <= !w;
      i_araddr <= a;
      i_rready <= !w;
      for (int k = 0; !dn; k++) begin
         if (k == 50) conclude(1'b1);
         @(negedge i_mclk);
         ta = pa && o_awready;
         tw = pw && o_wready;
         tr = pr && o_arready;
         dn = w ? o_bvalid : o_rvalid;
         r = w ? o_bresp : o_rresp;
         rdv = o_rdata;
         @(posedge i_mclk);
         pa = pa && !ta;
         pw = pw && !tw;
         pr = pr && !tr;
         i_awvalid <= pa;
         i_wvalid <= pw;
         i_arvalid <= pr;
         i_bready <= w && !dn;
         i_rready <= !w && !dn;
      end
      `CHK(r, er)
      if (!w) `CHK(rdv, {24'h0, d})
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input tmc_resp_t er = 2'h0);
      acc(1'b1, a, d, er);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] d, input tmc_resp_t er = 2'h0);
      acc(1'b0, a, d, er);
   endtask
   // Cycles until the next wrap pulse, events latched there
   task automatic wait_ovf(output int n);
      n = 0;
      @(negedge i_mclk);
      while (o_overflow !== 1'b1) begin
         if (n == 300) conclude(1'b1);
         @(negedge i_mclk);
         n++;
      end
      tx_seen = o_tx_baud_tick;
      rx_seen = o_rx_baud_tick;
      adc_seen = o_adc_start;
   endtask
   // Stopped timer, count near wrap, then start in mode m
   task automatic arm(input logic [7:0] m);
      wr(adr_ctl, 8'h00);
      wr(adr_clo, 8'hf8);
      wr(adr_chi, 8'hff);
      wr(adr_ctl, m);
   endtask
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rstn <= 1'b1;
      rd(adr_div, 8'h00);
      rd(adr_ctl, 8'h00);
      wr(adr_div, 8'hff);
      rd(adr_div, 8'h38);
      wr(12'h004, 8'h5a, 2'h2);
      rd(12'h004, 8'h00, 2'h2);
      // High half holds while stopped
      wr(adr_clo, 8'h00);
      wr(adr_chi, 8'h12);
      repeat (20) @(posedge i_mclk);
      rd(adr_chi, 8'h12);
      // Pin falls count with the pin source selected, and not when stopped
      wr(adr_ctl, 8'h06);
      u_tmc_pin_model.falls(1'b0, 5);
      rd(adr_clo, 8'h05);
      wr(adr_ctl, 8'h02);
      u_tmc_pin_model.falls(1'b0, 3);
      rd(adr_clo, 8'h05);
      // Every running mode at divide by one; reload value 0xfff0
      wr(adr_rlo, 8'hf0);
      wr(adr_rhi, 8'hff);
      foreach (modes[i]) begin
         arm(modes[i]);
         wait_ovf(cyc);
         `CHK(cyc <= 10, 1'b1)
         `CHK(tx_seen, modes[i][4])
         `CHK(rx_seen, modes[i][5])
         `CHK(adc_seen, 1'b1)
         rd(adr_ctl, 8'h80 | modes[i]);
         rd(adr_chi, (modes[i] == 8'h05) ? 8'h00 : 8'hff);
      end
      // Divide by twelve: eight ticks to the wrap
      wr(adr_div, 8'h00);
      arm(8'h04);
      wait_ovf(cyc);
      `CHK(cyc inside {[75:100]}, 1'b1)
      // Capture pin copies the fresh count into the reload pair
      wr(adr_ctl, 8'h05);
      wait_ovf(cyc);
      u_tmc_pin_model.falls(1'b1, 1);
      rd(adr_rhi, 8'h00);
      `CHK(u_tmc_pin_model.n_tx != 0, 1'b1)
      `CHK(u_tmc_pin_model.n_rx != 0, 1'b1)
      conclude(1'b0);
   end
endmodule
